// ### ckgr_host.sv
// serial bus host model driving the clock and data lines
`timescale 1ns/1ns
`default_nettype none
module ckgr_host (
  // bench clock
  input wire logic mclk,
  // bus lines
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // clock stands high and data released between frames
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic start();
    sda_low = 1'h0;
    tick(2);
    scl = 1'h1;
    tick(4);
    sda_low = 1'h1;
    tick(4);
    scl = 1'h0;
  endtask
  // eight bits msb first then acknowledge
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      tick(2);
      sda_low = !tx[i];
      tick(6);
      scl = 1'h1;
      tick(4);
      rx[i] = sda;
      tick(4);
      scl = 1'h0;
    end
  endtask
  task automatic stop();
    tick(2);
    sda_low = 1'h1;
    tick(6);
    scl = 1'h1;
    tick(4);
    sda_low = 1'h0;
    tick(8);
  endtask
endmodule // ckgr_host
`default_nettype wire

// ### ckgr_pkg.sv
// shared constants and types of the clock generator control/id register block
package ckgr_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h69;
  localparam logic [3:0] REG_CTRL_IDX = 4'h6;
  localparam logic [3:0] REG_ID_IDX = 4'h7;
  localparam logic [3:0] REG_READBACK_IDX = 4'h5;
  localparam logic [3:0] LAST_REG_IDX = 4'h7;
  localparam logic [7:0] BLOCK_COUNT = 8'h08;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam int CTRL_REF_BIT = 7;
  localparam int CTRL_CLK2_BIT = 6;
  localparam int CTRL_TOGGLE_BIT = 0;
  localparam logic CTRL_RESET_BIT = 1'b0;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam int SYNC_W = 11;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRX, ST_WR_ACK, ST_RD, ST_RD_HACK
  } ckgr_state_e;

  // synchronised pin levels
  typedef struct packed {
    logic scl;
    logic sda;
    logic proc_halt_n;
    logic pci_halt_n;
    logic mem_halt_n;
    logic mobile_mode;
    logic graphics_rate_select;
    logic [3:0] freq_select_pins;
  } ckgr_pins_s;
endpackage

// ### ckgr_regs.sv
// serial-bus control and identification registers of the clock generator
`timescale 1ns/1ns
`default_nettype none
module ckgr_regs import ckgr_pkg::*; #(
  // value is arbitrary, stands for the maker code
  parameter logic [7:0] MAKER_ID = 8'h5A
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // serial bus pins
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // device pins
  input wire logic proc_halt_n,
  input wire logic pci_halt_n,
  input wire logic mem_halt_n,
  input wire logic mobile_mode,
  input wire logic graphics_rate_select,
  input wire logic [3:0] freq_select_pins,
  // clock control outputs
  output logic ref_drive_double,
  output logic [2:0] proc_clk_en,
  output logic graphics_rate_sel_eff,
  output logic [3:0] freq_select_latched
);
  typedef struct packed {
    ckgr_state_e st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic [3:0] widx;
    logic [3:0] ridx;
    logic [7:0] tx;
    logic sda_oe_n;
    logic ref2x;
    logic clk2free;
    logic agp_toggle;
    logic [1:0] strap_cnt;
    logic strapped;
    logic agp_latched;
    logic [3:0] fs_latched;
    logic [2:0] proc_en;
    logic agp_eff;
    logic scl_prev;
    logic sda_prev;
  } ckgr_state_s;

  ckgr_pins_s pin_s;
  ckgr_state_s s_reg, s_next;
  logic scl_rise, scl_fall, start_seen, stop_seen;
  logic [7:0] ctrl_byte;
  logic [7:0] rd_byte;
  logic [3:0] reg_idx;
  logic stop_proc;

  ckgr_sync u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in({scl, sda_in, proc_halt_n, pci_halt_n, mem_halt_n, mobile_mode,
               graphics_rate_select, freq_select_pins}),
    .sync_out(pin_s)
  );

  assign scl_rise = pin_s.scl & ~s_reg.scl_prev;
  assign scl_fall = ~pin_s.scl & s_reg.scl_prev;
  assign start_seen = pin_s.scl & s_reg.scl_prev & s_reg.sda_prev & ~pin_s.sda;
  assign stop_seen = pin_s.scl & s_reg.scl_prev & ~s_reg.sda_prev & pin_s.sda;

  assign ctrl_byte = {s_reg.ref2x, s_reg.clk2free, s_reg.agp_eff, pin_s.mobile_mode,
                      pin_s.proc_halt_n, pin_s.pci_halt_n, pin_s.mem_halt_n,
                      s_reg.agp_toggle};

  assign reg_idx = s_reg.ridx - 4'h1;
  always_comb begin
    rd_byte = 8'h00;
    if (s_reg.ridx == 4'h0) begin
      rd_byte = BLOCK_COUNT;
    end else if (s_reg.ridx > LAST_REG_IDX + 4'h1) begin
      rd_byte = FILL_BYTE;
    end else if (reg_idx == REG_CTRL_IDX) begin
      rd_byte = ctrl_byte;
    end else if (reg_idx == REG_ID_IDX) begin
      rd_byte = MAKER_ID;
    end else if (reg_idx == REG_READBACK_IDX) begin
      rd_byte = {s_reg.fs_latched, 4'h0};
    end
  end

  assign stop_proc = pin_s.mobile_mode & ~pin_s.proc_halt_n;

  always_comb begin
    s_next = s_reg;
    s_next.scl_prev = pin_s.scl;
    s_next.sda_prev = pin_s.sda;
    // straps caught once the synchroniser has settled after reset
    if (!s_reg.strapped) begin
      if (s_reg.strap_cnt == STRAP_WAIT) begin
        s_next.strapped = 1'b1;
        s_next.agp_latched = pin_s.graphics_rate_select;
        s_next.fs_latched = ~pin_s.freq_select_pins;
      end else begin
        s_next.strap_cnt = s_reg.strap_cnt + 2'h1;
      end
    end
    s_next.agp_eff = s_reg.agp_latched ^ s_reg.agp_toggle;
    s_next.proc_en[0] = ~stop_proc;
    s_next.proc_en[1] = ~stop_proc;
    s_next.proc_en[2] = ~stop_proc | s_reg.clk2free;

    if (stop_seen) begin
      s_next.st = ST_IDLE;
      s_next.sda_oe_n = 1'b1;
    end else if (start_seen) begin
      s_next.st = ST_ADDR;
      s_next.bitcnt = 4'h0;
      s_next.sda_oe_n = 1'b1;
    end else if (scl_rise) begin
      case (s_reg.st)
        ST_ADDR, ST_WRX: begin
          s_next.shreg = {s_reg.shreg[6:0], pin_s.sda};
          s_next.bitcnt = s_reg.bitcnt + 4'h1;
        end
        // host nack ends the read
        ST_RD_HACK: s_next.rw = ~pin_s.sda;
        default: s_next.bitcnt = s_reg.bitcnt;
      endcase
    end else if (scl_fall) begin
      case (s_reg.st)
        ST_ADDR: begin
          if (s_reg.bitcnt == 4'h8) begin
            if (s_reg.shreg[7:1] == DEV_ADDR) begin
              s_next.st = ST_ADDR_ACK;
              s_next.rw = s_reg.shreg[0];
              s_next.sda_oe_n = 1'b0;
            end else begin
              s_next.st = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          s_next.bitcnt = 4'h0;
          s_next.widx = 4'h0;
          if (s_reg.rw) begin
            s_next.st = ST_RD;
            s_next.ridx = 4'h1;
            s_next.tx = {BLOCK_COUNT[6:0], 1'b0};
            s_next.bitcnt = 4'h1;
            s_next.sda_oe_n = BLOCK_COUNT[7];
          end else begin
            s_next.st = ST_WRX;
            s_next.sda_oe_n = 1'b1;
          end
        end
        ST_WRX: begin
          if (s_reg.bitcnt == 4'h8) begin
            if (s_reg.widx == 4'h2 + REG_CTRL_IDX) begin
              s_next.ref2x = s_reg.shreg[CTRL_REF_BIT];
              s_next.clk2free = s_reg.shreg[CTRL_CLK2_BIT];
              s_next.agp_toggle = s_reg.shreg[CTRL_TOGGLE_BIT];
            end
            if (s_reg.widx != 4'hF) begin
              s_next.widx = s_reg.widx + 4'h1;
            end
            s_next.st = ST_WR_ACK;
            s_next.sda_oe_n = 1'b0;
          end
        end
        ST_WR_ACK: begin
          s_next.st = ST_WRX;
          s_next.bitcnt = 4'h0;
          s_next.sda_oe_n = 1'b1;
        end
        ST_RD: begin
          if (s_reg.bitcnt == 4'h8) begin
            s_next.st = ST_RD_HACK;
            s_next.sda_oe_n = 1'b1;
          end else begin
            s_next.sda_oe_n = s_reg.tx[7];
            s_next.tx = {s_reg.tx[6:0], 1'b0};
            s_next.bitcnt = s_reg.bitcnt + 4'h1;
          end
        end
        ST_RD_HACK: begin
          if (s_reg.rw) begin
            s_next.st = ST_RD;
            s_next.tx = {rd_byte[6:0], 1'b0};
            s_next.sda_oe_n = rd_byte[7];
            s_next.bitcnt = 4'h1;
            if (s_reg.ridx != 4'hF) begin
              s_next.ridx = s_reg.ridx + 4'h1;
            end
          end else begin
            s_next.st = ST_IDLE;
          end
        end
        default: s_next.st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.sda_oe_n <= 1'b1;
      s_reg.ref2x <= CTRL_RESET_BIT;
      s_reg.clk2free <= CTRL_RESET_BIT;
      s_reg.agp_toggle <= CTRL_RESET_BIT;
      s_reg.proc_en <= 3'h7;
      s_reg.scl_prev <= 1'b1;
      s_reg.sda_prev <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // open-drain: only ever pulls low
  always_ff @(posedge mclk) begin
    sda_out <= 1'b0;
  end

  assign sda_oe_n = s_reg.sda_oe_n;
  assign ref_drive_double = s_reg.ref2x;
  assign proc_clk_en = s_reg.proc_en;
  assign graphics_rate_sel_eff = s_reg.agp_eff;
  assign freq_select_latched = s_reg.fs_latched;
endmodule // ckgr_regs
`default_nettype wire

// ### ckgr_regs_asserts.sv
// port checker of the control and id register block
`timescale 1ns/1ns
`default_nettype none
module ckgr_regs_asserts import ckgr_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // bus pins
  input wire logic scl,
  input wire logic sda_oe_n,
  // device pins
  input wire logic proc_halt_n,
  input wire logic mobile_mode,
  input wire logic [3:0] freq_select_pins,
  // clock control outputs
  input wire logic ref_drive_double,
  input wire logic [2:0] proc_clk_en,
  input wire logic graphics_rate_sel_eff,
  input wire logic [3:0] freq_select_latched
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_reset_vals: assert property ($fell(sys_rst) |->
    !ref_drive_double && sda_oe_n && proc_clk_en == 3'h7 && !graphics_rate_sel_eff)
    else $error("reset state wrong");
  a_halt_stops: assert property ((mobile_mode && !proc_halt_n)[*6] |->
    proc_clk_en[1:0] == 2'h0) else $error("halted clocks run");
  a_desk_runs: assert property ((!mobile_mode)[*6] |-> proc_clk_en == 3'h7)
    else $error("desktop clocks stopped");
  a_clk2_free: assert property (!proc_clk_en[2] |-> !proc_clk_en[1])
    else $error("third clock stopped alone");
  a_fs_invert: assert property ($changed(freq_select_latched) |->
    freq_select_latched == ~$past(freq_select_pins, 3)) else $error("fs not inverted");
  a_ref_at_ack: assert property ($changed(ref_drive_double) |-> ##[0:4] !sda_oe_n)
    else $error("strength changed outside ack");
  a_sda_timing: assert property ($changed(sda_oe_n) |-> !$past(scl, 2))
    else $error("sda moved while scl high");
  a_ack_len: assert property ($fell(sda_oe_n) |-> !sda_oe_n[*8])
    else $error("driven bit too short");
endmodule // ckgr_regs_asserts
bind ckgr_regs ckgr_regs_asserts chk (
  .mclk(mclk), .sys_rst(sys_rst), .scl(scl), .sda_oe_n(sda_oe_n),
  .proc_halt_n(proc_halt_n), .mobile_mode(mobile_mode), .freq_select_pins(freq_select_pins),
  .ref_drive_double(ref_drive_double), .proc_clk_en(proc_clk_en),
  .graphics_rate_sel_eff(graphics_rate_sel_eff), .freq_select_latched(freq_select_latched)
);
`default_nettype wire

// ### ckgr_regs_tb.sv
// self-checking bench of the control and id register block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module ckgr_regs_tb import ckgr_pkg::*; ;
  // value is arbitrary, stands for the maker code
  localparam logic [7:0] TB_ID = 8'h3C;
  logic mclk, sys_rst, scl, sda_low, sda_in, sda_out, sda_oe_n;
  logic proc_halt_n, pci_halt_n, mem_halt_n, mobile_mode, graphics_rate_select;
  logic [3:0] freq_select_pins, freq_select_latched;
  logic ref_drive_double, graphics_rate_sel_eff;
  logic [2:0] proc_clk_en;
  logic [8:0] rx;
  logic [7:0] rb [0:8];
  int errors, n_compared;
  // open drain with pull-up
  assign sda_in = !(sda_low || (!sda_oe_n && !sda_out));
  ckgr_regs #(.MAKER_ID(TB_ID)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .proc_halt_n(proc_halt_n), .pci_halt_n(pci_halt_n),
    .mem_halt_n(mem_halt_n), .mobile_mode(mobile_mode),
    .graphics_rate_select(graphics_rate_select), .freq_select_pins(freq_select_pins),
    .ref_drive_double(ref_drive_double), .proc_clk_en(proc_clk_en),
    .graphics_rate_sel_eff(graphics_rate_sel_eff), .freq_select_latched(freq_select_latched)
  );
  ckgr_host host (.mclk(mclk), .sda(sda_in), .scl(scl), .sda_low(sda_low));
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  task automatic wr(input logic [7:0] v, input int n);
    host.start();
    host.xfer({DEV_ADDR, 1'h0, 1'h1}, rx);
    `CHK(rx[0], 1'h0)
    for (int i = 0; i < n + 2; i++) begin
      host.xfer({(i >= 8) ? v : 8'h00, 1'h1}, rx);
      `CHK(rx[0], 1'h0)
    end
    host.stop();
  endtask
  task automatic rd();
    host.start();
    host.xfer({DEV_ADDR, 1'h1, 1'h1}, rx);
    `CHK(rx[0], 1'h0)
    for (int i = 0; i < 9; i++) begin
      host.xfer({8'hFF, i == 8}, rx);
      rb[i] = rx[8:1];
    end
    host.stop();
  endtask
  task automatic wrap_up();
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    wrap_up();
  end
  initial begin
    errors = 0;
    n_compared = 0;
    sys_rst = 1'h1;
    {proc_halt_n, pci_halt_n, mem_halt_n, mobile_mode} = 4'hB;
    graphics_rate_select = 1'h1;
    freq_select_pins = 4'hA;
    repeat (2) @(posedge mclk);
    #1 sys_rst = 1'h0;
    host.tick(8);
    `CHK({ref_drive_double, proc_clk_en, graphics_rate_sel_eff}, 5'h0F)
    `CHK(freq_select_latched, 4'h5)
    // rb[0] is the count byte, so register n sits at rb[n+1]
    rd();
    `CHK(rb[0], BLOCK_COUNT)
    `CHK(rb[6][7:4], 4'h5)
    `CHK(rb[7], 8'h3A)
    `CHK(rb[8], TB_ID)
    proc_halt_n = 1'h0;
    host.tick(4);
    `CHK(proc_clk_en, 3'h0)
    wr(8'hFF, 8);
    `CHK({ref_drive_double, proc_clk_en, graphics_rate_sel_eff}, 5'h18)
    rd();
    `CHK(rb[7], 8'hD3)
    `CHK(rb[8], TB_ID)
    // stop before the control byte leaves it alone
    wr(8'h00, 6);
    `CHK(ref_drive_double, 1'h1)
    mobile_mode = 1'h0;
    wr(8'h00, 7);
    `CHK({ref_drive_double, proc_clk_en, graphics_rate_sel_eff}, 5'h0F)
    rd();
    `CHK(rb[7], 8'h22)
    // foreign address gets no acknowledge
    host.start();
    host.xfer({7'h2A, 1'h0, 1'h1}, rx);
    `CHK(rx[0], 1'h1)
    host.stop();
    wrap_up();
  end
endmodule // ckgr_regs_tb
`default_nettype wire

// ### ckgr_sync.sv
// two-flop synchroniser for every asynchronous input bit
`timescale 1ns/1ns
`default_nettype none
module ckgr_sync import ckgr_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // raw and synchronised levels
  input wire logic [SYNC_W-1:0] async_in,
  output logic [SYNC_W-1:0] sync_out
);
  logic [SYNC_W-1:0] meta_reg;

  genvar i;
  generate
    for (i = 0; i < SYNC_W; i++) begin : g_bit
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          meta_reg[i] <= 1'b1;
          sync_out[i] <= 1'b1;
        end else begin
          meta_reg[i] <= async_in[i];
          sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule // ckgr_sync
`default_nettype wire
